// File: rtl/gas_cal_consts.svh
// Purpose: Offsets, field positions, reset values and constants of the gas calibration block.
// Assumes: Register addresses are word addresses within each register space.
// Notes: Included by the register block module only; the package and the divider do not include it.
//
// Functional notes
// - Carbon dioxide span recalibration works in triggered and continuous sampling alike.
// - Input register 1 shows the current carbon dioxide measurement.
// - Carbon dioxide reading is in hundredths of a percent, 14 percent reads 1400.
// - Holding register 5 holds the carbon dioxide span factor, readable and writable.
// - Readings scale with the stored span factor, so rewriting it corrects later readings.
// - Oxygen span recalibration works in either sampling mode, with ambient air only.
// - Holding register 4 holds a writable oxygen baseline offset added to the reading.
// - Input register 2 shows oxygen in tenths of a percent, ambient reads 209.
// - Confirm coil 7 after a request starts oxygen span calibration assuming 20.9 percent.
// - After a confirmed action the device clears request and confirm coils itself.
// - Ambient oxygen calibration stores the new oxygen span factor in holding register 3.
// - Holding register 3 is readable and a written value becomes the oxygen factor.
// - Sampling period register 20: zero selects continuous, nonzero triggered, default 300.
`ifndef GAS_CAL_CONSTS_SVH
`define GAS_CAL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_IN_CO2_READING 8'h01
`define ADDR_IN_O2_READING 8'h02
`define ADDR_HOLD_O2_SPAN 8'h03
`define ADDR_HOLD_O2_OFFSET 8'h04
`define ADDR_HOLD_CO2_SPAN 8'h05
`define ADDR_HOLD_SAMPLE_PERIOD 8'h14
`define ADDR_COIL_O2_AMBIENT_REQ 8'h01
`define ADDR_COIL_CAL_CONFIRM 8'h07

// ----------------------------------------------------------------------
// Reset values and scaling
// ----------------------------------------------------------------------
`define RST_O2_SPAN 16'h0100
`define RST_O2_OFFSET 16'h0000
`define RST_CO2_SPAN 16'h2000
`define RST_SAMPLE_PERIOD 16'h012c
`define CO2_SPAN_SHIFT 13
`define O2_SPAN_SHIFT 8
`define O2_AMBIENT_TENTHS 16'h00d1

`endif

// File: rtl/gas_cal_pkg.sv
// Purpose: Types shared by the gas calibration block.
// Assumes: Nothing beyond the constants header.
// Notes: Constants live in the header as macros.
package gas_cal_pkg;

  typedef enum logic [1:0] {
    SPACE_INPUT = 2'h0,
    SPACE_HOLDING = 2'h1,
    SPACE_COIL = 2'h2
  } reg_space_t;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'h1,
    CAL_DIVIDE = 3'h2,
    CAL_STORE = 3'h4
  } cal_state_t;

endpackage : gas_cal_pkg

// File: rtl/gas_span_calibration_regs.sv
// Purpose: Register map and calibration command handling of the gas sensor module.
// Assumes: The fieldbus frame layer delivers decoded register accesses one at a time.
// Notes: Answers come one cycle after each request; the oxygen calibration takes about 35 cycles.
`timescale 1ns/1ps
`include "gas_cal_consts.svh"
module gas_span_calibration_regs #(
  parameter int DATA_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register access from the fieldbus frame layer.
  input wire logic req_valid,
  input wire logic req_write,
  input wire gas_cal_pkg::reg_space_t req_space,
  input wire logic [7:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic rsp_error,
  // Raw sensor samples.
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] co2_raw,
  input wire logic [DATA_W-1:0] o2_raw,
  // Sampling control toward the measurement sequencer.
  output logic sampling_continuous,
  output logic [DATA_W-1:0] sampling_period,
  // Calibration status.
  output logic cal_busy
);

  if (DATA_W != 16) begin : g_bad_data_w
    $error("gas_span_calibration_regs: DATA_W must be 16");
  end

  localparam int PW = 2 * DATA_W;

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  function automatic logic [DATA_W-1:0] sat_word(input logic [PW-1:0] v);
    if (v[PW-1:DATA_W] != '0) begin
      sat_word = '1;
    end else begin
      sat_word = v[DATA_W-1:0];
    end
  endfunction : sat_word

  function automatic logic [PW-1:0] mul_word(input logic [DATA_W-1:0] a,
                                             input logic [DATA_W-1:0] b);
    mul_word = PW'(a) * PW'(b);
  endfunction : mul_word

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] co2_span_q, co2_span_d;
  logic [DATA_W-1:0] o2_span_q, o2_span_d;
  logic [DATA_W-1:0] o2_offset_q, o2_offset_d;
  logic [DATA_W-1:0] period_q, period_d;
  logic [DATA_W-1:0] co2_reading_q, co2_reading_d;
  logic [DATA_W-1:0] o2_base_q, o2_base_d;
  logic [DATA_W-1:0] o2_reading_q, o2_reading_d;
  logic req_coil_q, req_coil_d;
  logic confirm_q, confirm_d;
  gas_cal_pkg::cal_state_t state_q, state_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [DATA_W-1:0] rsp_rdata_q, rsp_rdata_d;
  logic rsp_error_q, rsp_error_d;
  logic div_start;
  logic div_busy;
  logic div_done;
  logic [PW-1:0] div_quot;
  logic [PW-1:0] div_num;

  // New factor = 20.9 percent times the factor over the uncorrected reading, rounded.
  assign div_num = mul_word(`O2_AMBIENT_TENTHS, o2_span_q) + PW'(o2_base_q >> 1);

  span_divider #(
    .WIDTH(PW)
  ) u_div (
    .clk(clk),
    .reset(reset),
    .start(div_start),
    .numerator(div_num),
    .denominator(PW'(o2_base_q)),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_quot)
  );

  // ----------------------------------------------------------------------
  // Next values.
  // ----------------------------------------------------------------------
  always_comb begin
    logic wr_hold;
    logic wr_coil;
    wr_hold = req_valid && req_write && req_space == gas_cal_pkg::SPACE_HOLDING;
    wr_coil = req_valid && req_write && req_space == gas_cal_pkg::SPACE_COIL;
    co2_span_d = co2_span_q;
    o2_span_d = o2_span_q;
    o2_offset_d = o2_offset_q;
    period_d = period_q;
    co2_reading_d = co2_reading_q;
    o2_base_d = o2_base_q;
    o2_reading_d = o2_reading_q;
    req_coil_d = req_coil_q;
    confirm_d = confirm_q;
    state_d = state_q;
    div_start = 1'b0;
    rsp_valid_d = req_valid;
    rsp_rdata_d = '0;
    rsp_error_d = 1'b0;

    // Readings follow the stored factors on every sample.
    if (sample_valid) begin
      co2_reading_d = sat_word(mul_word(co2_raw, co2_span_q) >> `CO2_SPAN_SHIFT);
      o2_base_d = sat_word(mul_word(o2_raw, o2_span_q) >> `O2_SPAN_SHIFT);
      o2_reading_d = sat_word(mul_word(o2_raw, o2_span_q) >> `O2_SPAN_SHIFT)
                     + o2_offset_q;
    end

    // Register writes; no gating by sampling mode.
    if (wr_hold) begin
      unique case (req_addr)
        `ADDR_HOLD_O2_SPAN: o2_span_d = req_wdata;
        `ADDR_HOLD_O2_OFFSET: o2_offset_d = req_wdata;
        `ADDR_HOLD_CO2_SPAN: co2_span_d = req_wdata;
        `ADDR_HOLD_SAMPLE_PERIOD: period_d = req_wdata;
        default: rsp_error_d = 1'b1;
      endcase
    end
    if (wr_coil) begin
      unique case (req_addr)
        `ADDR_COIL_O2_AMBIENT_REQ: req_coil_d = req_wdata[0];
        `ADDR_COIL_CAL_CONFIRM: confirm_d = req_wdata[0];
        default: rsp_error_d = 1'b1;
      endcase
    end

    // Register reads.
    if (req_valid && !req_write) begin
      unique case (req_space)
        gas_cal_pkg::SPACE_INPUT: begin
          unique case (req_addr)
            `ADDR_IN_CO2_READING: rsp_rdata_d = co2_reading_q;
            `ADDR_IN_O2_READING: rsp_rdata_d = o2_reading_q;
            default: rsp_error_d = 1'b1;
          endcase
        end
        gas_cal_pkg::SPACE_HOLDING: begin
          unique case (req_addr)
            `ADDR_HOLD_O2_SPAN: rsp_rdata_d = o2_span_q;
            `ADDR_HOLD_O2_OFFSET: rsp_rdata_d = o2_offset_q;
            `ADDR_HOLD_CO2_SPAN: rsp_rdata_d = co2_span_q;
            `ADDR_HOLD_SAMPLE_PERIOD: rsp_rdata_d = period_q;
            default: rsp_error_d = 1'b1;
          endcase
        end
        gas_cal_pkg::SPACE_COIL: begin
          unique case (req_addr)
            `ADDR_COIL_O2_AMBIENT_REQ: rsp_rdata_d = DATA_W'(req_coil_q);
            `ADDR_COIL_CAL_CONFIRM: rsp_rdata_d = DATA_W'(confirm_q);
            default: rsp_error_d = 1'b1;
          endcase
        end
        default: rsp_error_d = 1'b1;
      endcase
    end
    if (req_valid && req_write && req_space != gas_cal_pkg::SPACE_HOLDING
        && req_space != gas_cal_pkg::SPACE_COIL) begin
      rsp_error_d = 1'b1;
    end

    // Calibration sequence.
    unique case (state_q)
      gas_cal_pkg::CAL_IDLE: begin
        if (confirm_q) begin
          if (req_coil_q && o2_base_q != '0) begin
            div_start = 1'b1;
            state_d = gas_cal_pkg::CAL_DIVIDE;
          end else begin
            req_coil_d = 1'b0;
            confirm_d = 1'b0;
          end
        end
      end
      gas_cal_pkg::CAL_DIVIDE: begin
        if (div_done) begin
          state_d = gas_cal_pkg::CAL_STORE;
        end
      end
      gas_cal_pkg::CAL_STORE: begin
        o2_span_d = sat_word(div_quot);
        req_coil_d = 1'b0;
        confirm_d = 1'b0;
        state_d = gas_cal_pkg::CAL_IDLE;
      end
      default: state_d = gas_cal_pkg::CAL_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      co2_span_q <= `RST_CO2_SPAN;
      o2_span_q <= `RST_O2_SPAN;
      o2_offset_q <= `RST_O2_OFFSET;
      period_q <= `RST_SAMPLE_PERIOD;
      co2_reading_q <= '0;
      o2_base_q <= '0;
      o2_reading_q <= '0;
      req_coil_q <= 1'b0;
      confirm_q <= 1'b0;
      state_q <= gas_cal_pkg::CAL_IDLE;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
      rsp_error_q <= 1'b0;
    end else begin
      co2_span_q <= co2_span_d;
      o2_span_q <= o2_span_d;
      o2_offset_q <= o2_offset_d;
      period_q <= period_d;
      co2_reading_q <= co2_reading_d;
      o2_base_q <= o2_base_d;
      o2_reading_q <= o2_reading_d;
      req_coil_q <= req_coil_d;
      confirm_q <= confirm_d;
      state_q <= state_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_rdata_q <= rsp_rdata_d;
      rsp_error_q <= rsp_error_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign rsp_error = rsp_error_q;
  assign sampling_continuous = (period_q == '0);
  assign sampling_period = period_q;
  assign cal_busy = (state_q != gas_cal_pkg::CAL_IDLE) || div_busy;

endmodule : gas_span_calibration_regs

// File: rtl/span_divider.sv
// Purpose: Sequential unsigned divider used to compute a new span factor.
// Assumes: start is a one-cycle pulse given only while busy is low.
// Notes: Takes WIDTH cycles; division by zero returns all ones.
`timescale 1ns/1ps
module span_divider #(
  parameter int WIDTH = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Request.
  input wire logic start,
  input wire logic [WIDTH-1:0] numerator,
  input wire logic [WIDTH-1:0] denominator,
  // Result.
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] quotient
);

  if (WIDTH < 2 || WIDTH > 64) begin : g_bad_width
    $error("span_divider: WIDTH out of range");
  end

  logic [WIDTH-1:0] rem_q, rem_d;
  logic [WIDTH-1:0] quo_q, quo_d;
  logic [WIDTH-1:0] den_q, den_d;
  logic [7:0] cnt_q, cnt_d;
  logic done_q, done_d;

  // ----------------------------------------------------------------------
  // One quotient bit per cycle.
  // ----------------------------------------------------------------------
  always_comb begin
    logic [WIDTH:0] trial;
    trial = '0;
    rem_d = rem_q;
    quo_d = quo_q;
    den_d = den_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (start && cnt_q == 8'h00) begin
      rem_d = '0;
      quo_d = numerator;
      den_d = denominator;
      cnt_d = 8'(WIDTH);
    end else if (cnt_q != 8'h00) begin
      trial = {rem_q, quo_q[WIDTH-1]};
      quo_d = {quo_q[WIDTH-2:0], 1'b0};
      if (trial >= {1'b0, den_q}) begin
        trial = trial - {1'b0, den_q};
        quo_d[0] = 1'b1;
      end
      rem_d = trial[WIDTH-1:0];
      cnt_d = cnt_q - 8'h01;
      done_d = (cnt_q == 8'h01);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rem_q <= '0;
      quo_q <= '0;
      den_q <= '0;
      cnt_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      rem_q <= rem_d;
      quo_q <= quo_d;
      den_q <= den_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (cnt_q != 8'h00);
  assign done = done_q;
  assign quotient = quo_q;

endmodule : span_divider

// File: verif/fieldbus_master_model.sv
// Purpose: Fieldbus master issuing register accesses to the block.
// Assumes: Answer comes one cycle after the request.
// Notes: Drives at the falling edge; released data is inverted.
`timescale 1ns/1ps
module fieldbus_master_model (
  // Clock.
  input wire logic clk,
  // Request.
  output logic req_valid,
  output logic req_write,
  output gas_cal_pkg::reg_space_t req_space,
  output logic [7:0] req_addr,
  output logic [15:0] req_wdata,
  // Answer.
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic rsp_error
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_space = gas_cal_pkg::SPACE_INPUT;
    req_addr = 8'h00;
    req_wdata = 16'h0000;
  end
  task automatic access(input logic w, input gas_cal_pkg::reg_space_t sp, input logic [7:0] a,
      input logic [15:0] d, output logic [15:0] rdata, output logic err);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_space = sp;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    rdata = rsp_rdata;
    err = rsp_error | ~rsp_valid;
    req_valid = 1'b0;
    req_wdata = ~d;
  endtask : access
  task automatic cal_ambient();
    logic [15:0] r;
    logic e;
    access(1'b1, gas_cal_pkg::SPACE_COIL, 8'h01, 16'h0001, r, e);
    access(1'b1, gas_cal_pkg::SPACE_COIL, 8'h07, 16'h0001, r, e);
  endtask : cal_ambient
endmodule : fieldbus_master_model

// File: verif/gas_cal_regs_sva.sv
// Purpose: Port-level checks of the gas calibration register block.
// Assumes: One clock domain, reset active high.
// Notes: Bound into the design top module.
`timescale 1ns/1ps
module gas_cal_regs_sva #(
  parameter int DATA_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register access.
  input wire logic req_valid,
  input wire logic req_write,
  input wire gas_cal_pkg::reg_space_t req_space,
  input wire logic [7:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [DATA_W-1:0] rsp_rdata,
  input wire logic rsp_error,
  // Status.
  input wire logic sampling_continuous,
  input wire logic [DATA_W-1:0] sampling_period,
  input wire logic cal_busy
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic per_wr;
  assign per_wr = req_valid && req_write && req_space == gas_cal_pkg::SPACE_HOLDING
    && req_addr == 8'h14;
  a_rsp_follows_req: assert property (req_valid |=> rsp_valid)
    else $error("no answer one cycle after a request");
  a_no_stray_rsp: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without a request");
  a_error_data_zero: assert property (rsp_valid && rsp_error |-> rsp_rdata == '0)
    else $error("error answer carries data");
  a_cont_mode_flag: assert property (sampling_continuous == (sampling_period == '0))
    else $error("continuous flag disagrees with period");
  a_cal_busy_bound: assert property ($rose(cal_busy) |-> ##[1:40] !cal_busy)
    else $error("calibration runs too long");
  a_input_ro_err: assert property (req_valid && req_write
    && req_space == gas_cal_pkg::SPACE_INPUT |=> rsp_error)
    else $error("write to input register accepted");
  a_period_write: assert property (per_wr |=> sampling_period == $past(req_wdata))
    else $error("period write not taken");
  a_period_stable: assert property (!$stable(sampling_period) |-> $past(per_wr))
    else $error("period changed without a write");
  a_span_read_ok: assert property (req_valid && !req_write
    && req_space == gas_cal_pkg::SPACE_HOLDING && req_addr == 8'h05
    |=> rsp_valid && !rsp_error)
    else $error("span read refused");
  c_cal_run: cover property ($fell(cal_busy));
  c_error_rsp: cover property (rsp_valid && rsp_error);
  c_cont_mode: cover property (sampling_continuous);
endmodule : gas_cal_regs_sva

bind gas_span_calibration_regs gas_cal_regs_sva #(.DATA_W(DATA_W)) u_sva (.clk(clk),
  .reset(reset), .req_valid(req_valid), .req_write(req_write), .req_space(req_space),
  .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
  .rsp_error(rsp_error), .sampling_continuous(sampling_continuous),
  .sampling_period(sampling_period), .cal_busy(cal_busy));

// File: verif/gas_span_calibration_regs_tb_top.sv
// Purpose: Self-checking bench of the gas calibration register block.
// Assumes: Spans at reset give raw readings unscaled.
// Notes: Inputs change at the falling edge.
`timescale 1ns/1ps
module gas_span_calibration_regs_tb_top;
  localparam gas_cal_pkg::reg_space_t IN = gas_cal_pkg::SPACE_INPUT;
  localparam gas_cal_pkg::reg_space_t HO = gas_cal_pkg::SPACE_HOLDING;
  localparam gas_cal_pkg::reg_space_t CO = gas_cal_pkg::SPACE_COIL;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sample_valid = 1'b0;
  logic [15:0] co2_raw = 16'h0000;
  logic [15:0] o2_raw = 16'h0000;
  logic req_valid, req_write, rsp_valid, rsp_error, sampling_continuous, cal_busy, er;
  gas_cal_pkg::reg_space_t req_space;
  logic [7:0] req_addr;
  logic [15:0] req_wdata, rsp_rdata, sampling_period, rd;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  always #10 clk = ~clk;
  gas_span_calibration_regs #(.DATA_W(16)) dut (.clk(clk), .reset(reset),
    .req_valid(req_valid), .req_write(req_write), .req_space(req_space), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_error(rsp_error), .sample_valid(sample_valid), .co2_raw(co2_raw), .o2_raw(o2_raw),
    .sampling_continuous(sampling_continuous), .sampling_period(sampling_period),
    .cal_busy(cal_busy));
  fieldbus_master_model mst (.clk(clk), .req_valid(req_valid), .req_write(req_write),
    .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic x(input logic w, input gas_cal_pkg::reg_space_t sp, input logic [7:0] a,
      input logic [15:0] d, input logic [15:0] exp, input logic ee);
    mst.access(w, sp, a, d, rd, er);
    check({15'h0000, er}, {15'h0000, ee});
    check(rd, exp);
  endtask : x
  task automatic sample(input logic [15:0] c, input logic [15:0] o);
    @(negedge clk);
    co2_raw = c;
    o2_raw = o;
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
  endtask : sample
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    x(0, HO, 8'h03, 0, 16'h0100, 0);
    x(0, HO, 8'h04, 0, 16'h0000, 0);
    x(0, HO, 8'h05, 0, 16'h2000, 0);
    x(0, HO, 8'h14, 0, 16'h012c, 0);
    x(0, CO, 8'h01, 0, 16'h0000, 0);
    x(0, CO, 8'h07, 0, 16'h0000, 0);
    sample(16'h0578, 16'h00c8);
    x(0, IN, 8'h01, 0, 16'h0578, 0);
    x(0, IN, 8'h02, 0, 16'h00c8, 0);
    x(1, HO, 8'h05, 16'h4000, 16'h0000, 0);
    x(0, HO, 8'h05, 0, 16'h4000, 0);
    sample(16'h0578, 16'h00c8);
    x(0, IN, 8'h01, 0, 16'h0af0, 0);
    x(1, HO, 8'h04, 16'h0005, 16'h0000, 0);
    sample(16'h0578, 16'h00c8);
    x(0, IN, 8'h02, 0, 16'h00cd, 0);
    x(1, HO, 8'h04, 16'h0000, 16'h0000, 0);
    x(1, HO, 8'h14, 16'h0000, 16'h0000, 0);
    check({15'h0000, sampling_continuous}, 16'h0001);
    check(sampling_period, 16'h0000);
    sample(16'h0578, 16'h00c8);
    mst.cal_ambient();
    x(0, CO, 8'h01, 0, 16'h0001, 0);
    for (n = 0; n < 45 && cal_busy !== 1'b0; n++) begin
      @(negedge clk);
    end
    check({15'h0000, cal_busy}, 16'h0000);
    x(0, HO, 8'h03, 0, 16'h010c, 0);
    x(0, CO, 8'h01, 0, 16'h0000, 0);
    x(0, CO, 8'h07, 0, 16'h0000, 0);
    sample(16'h0578, 16'h00c8);
    x(0, IN, 8'h02, 0, 16'h00d1, 0);
    x(1, CO, 8'h07, 16'h0001, 16'h0000, 0);
    repeat (3) @(negedge clk);
    x(0, CO, 8'h07, 0, 16'h0000, 0);
    x(0, HO, 8'h03, 0, 16'h010c, 0);
    x(1, HO, 8'h03, 16'h0200, 16'h0000, 0);
    x(0, HO, 8'h03, 0, 16'h0200, 0);
    x(0, HO, 8'h09, 0, 16'h0000, 1);
    x(0, gas_cal_pkg::reg_space_t'(2'h3), 8'h01, 0, 16'h0000, 1);
    x(1, IN, 8'h01, 16'h1234, 16'h0000, 1);
    x(0, IN, 8'h01, 0, 16'h0af0, 0);
    x(1, CO, 8'h01, 16'h0001, 16'h0000, 0);
    x(0, CO, 8'h01, 0, 16'h0001, 0);
    x(1, CO, 8'h01, 16'h0000, 16'h0000, 0);
    x(0, CO, 8'h01, 0, 16'h0000, 0);
    sample(16'h0578, 16'h0000);
    mst.cal_ambient();
    repeat (3) @(negedge clk);
    check({15'h0000, cal_busy}, 16'h0000);
    x(0, CO, 8'h01, 0, 16'h0000, 0);
    x(0, CO, 8'h07, 0, 16'h0000, 0);
    x(0, HO, 8'h03, 0, 16'h0200, 0);
    x(1, HO, 8'h14, 16'h012c, 16'h0000, 0);
    check({15'h0000, sampling_continuous}, 16'h0000);
    check(sampling_period, 16'h012c);
    summarize();
  end
endmodule : gas_span_calibration_regs_tb_top
